// ==== design/sdcp_pkg.sv ====
/*
  Shared constants for the sync delay and clock position capture block:
  register indices and byte addresses, field positions, reset values,
  delay step sizes and bus response codes.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package sdcp_pkg;

  // ==========================================================
  // register indices and byte addresses (index times four)
  localparam logic [7:0] SDCP_IDX_STEP = 8'h0D;
  localparam logic [7:0] SDCP_IDX_CAPT = 8'h0E;
  localparam logic [7:0] SDCP_IDX_SCTL = 8'h10;
  localparam logic [7:0] SDCP_IDX_SNAPLO = 8'h11;
  localparam logic [7:0] SDCP_IDX_SNAPHI = 8'h12;
  localparam logic [7:0] SDCP_IDX_STAT = 8'h13;
  localparam logic [7:0] SDCP_ADDR_STEP = {SDCP_IDX_STEP[5:0], 2'b00};
  localparam logic [7:0] SDCP_ADDR_CAPT = {SDCP_IDX_CAPT[5:0], 2'b00};
  localparam logic [7:0] SDCP_ADDR_SCTL = {SDCP_IDX_SCTL[5:0], 2'b00};
  localparam logic [7:0] SDCP_ADDR_SNAPLO = {SDCP_IDX_SNAPLO[5:0], 2'b00};
  localparam logic [7:0] SDCP_ADDR_SNAPHI = {SDCP_IDX_SNAPHI[5:0], 2'b00};
  localparam logic [7:0] SDCP_ADDR_STAT = {SDCP_IDX_STAT[5:0], 2'b00};

  // ==========================================================
  // field positions
  localparam int SDCP_CAPT_HOLD_BIT = 0;
  localparam int SDCP_CAPT_KEEP_BIT = 1;
  localparam int SDCP_CAPT_EN_BIT = 2;
  localparam int SDCP_SCTL_CLEAR_BIT = 0;
  localparam int SDCP_SCTL_TAPS_LSB = 1;
  localparam int SDCP_SCTL_EN_BIT = 13;

  // ==========================================================
  // reset values
  localparam logic [15:0] SDCP_STEP_RESET = 16'h0003;
  localparam logic [15:0] SDCP_CAPT_RESET = 16'h0002;
  localparam logic [15:0] SDCP_SCTL_RESET = 16'h0001;

  // ==========================================================
  // delay element step sizes in ps, by selector code
  localparam logic [4:0] SDCP_STEP_PS_0 = 5'h1C;
  localparam logic [4:0] SDCP_STEP_PS_1 = 5'h0F;
  localparam logic [4:0] SDCP_STEP_PS_2 = 5'h0B;
  localparam logic [4:0] SDCP_STEP_PS_3 = 5'h08;

  // ==========================================================
  // snapshot length and bus responses
  localparam logic [4:0] SDCP_SNAP_LAST = 5'h1F;
  localparam logic [1:0] SDCP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDCP_RESP_SLVERR = 2'h2;

endpackage

// ==== design/sdcp_reg_if.sv ====
/*
  Register access carrier between the bus slave and the register file.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/1ps

interface sdcp_reg_if;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic rdEn;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;

  modport bus (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
    input wrErr, rdData, rdErr);
  modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
    output wrErr, rdData, rdErr);
endinterface

// ==== design/sdcp_axil_slave.sv ====
/*
  AXI4-Lite slave front end: takes write address and data in either
  order, issues one write strobe, then a response; one read at a time.
  Assumes the register file answers decode and read data combinationally.
*/
`timescale 1ns/1ps

module sdcp_axil_slave
  import sdcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  sdcp_reg_if.bus regs
);

  logic awGot, wGot, arGot;
  logic next_awGot, next_wGot, next_arGot;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0] wAddr, rAddr, next_wAddr, next_rAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;

  // strobes toward the register file
  assign regs.wrEn = awGot && wGot && !bvalid;
  assign regs.wrAddr = wAddr;
  assign regs.wrData = wData;
  assign regs.wrStrb = wStrb;
  assign regs.rdEn = arGot && !rvalid;
  assign regs.rdAddr = rAddr;

  // next state of both channels
  always_comb begin
    next_awGot = awGot;
    next_wGot = wGot;
    next_arGot = arGot;
    next_awready = awready;
    next_wready = wready;
    next_arready = arready;
    next_bvalid = bvalid;
    next_rvalid = rvalid;
    next_bresp = bresp;
    next_rresp = rresp;
    next_rdata = rdata;
    next_wAddr = wAddr;
    next_rAddr = rAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    if (awvalid && awready) begin
      next_awGot = 1'b1;
      next_awready = 1'b0;
      next_wAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_wGot = 1'b1;
      next_wready = 1'b0;
      next_wData = wdata;
      next_wStrb = wstrb;
    end
    if (regs.wrEn) begin
      next_awGot = 1'b0;
      next_wGot = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = regs.wrErr ? SDCP_RESP_SLVERR : SDCP_RESP_OKAY;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arGot = 1'b1;
      next_arready = 1'b0;
      next_rAddr = araddr;
    end
    if (regs.rdEn) begin
      next_arGot = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = regs.rdData;
      next_rresp = regs.rdErr ? SDCP_RESP_SLVERR : SDCP_RESP_OKAY;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // channel registers
  always_ff @(posedge clk) begin
    if (rst) begin
      awGot <= 1'b0;
      wGot <= 1'b0;
      arGot <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      bresp <= SDCP_RESP_OKAY;
      rresp <= SDCP_RESP_OKAY;
      rdata <= 32'h00000000;
      wAddr <= 8'h00;
      rAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else begin
      awGot <= next_awGot;
      wGot <= next_wGot;
      arGot <= next_arGot;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
      wAddr <= next_wAddr;
      rAddr <= next_rAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
    end
  end

endmodule

// ==== design/sdcp_edge_window.sv ====
/*
  Windowing circuit: after a start pulse, fills a 32-bit snapshot of
  input clock samples from LSB to MSB, one sample per clock, then holds it.
  Assumes sample is already synchronised and clear is a level.
*/
`timescale 1ns/1ps

module sdcp_edge_window
  import sdcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic start,
  input wire logic sample,
  output logic [31:0] snapshot,
  output logic busy,
  output logic done
);

  logic [31:0] next_snapshot;
  logic next_busy, next_done;
  logic [4:0] count, next_count;

  // fill, finish and hold the snapshot
  always_comb begin
    next_snapshot = snapshot;
    next_busy = busy;
    next_done = done;
    next_count = count;
    if (clear) begin
      next_snapshot = 32'h00000000;
      next_busy = 1'b0;
      next_done = 1'b0;
      next_count = 5'h00;
    end else if (busy) begin
      next_snapshot[count] = sample;
      next_count = count + 5'h01;
      if (count == SDCP_SNAP_LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_snapshot[0] = 1'b1; // boundary bits set when the window finishes
        next_snapshot[31] = 1'b1;
      end
    end else if (start && !done) begin
      next_busy = 1'b1;
      next_count = 5'h00;
    end
  end

  // window registers
  always_ff @(posedge clk) begin
    if (rst) begin
      snapshot <= 32'h00000000;
      busy <= 1'b0;
      done <= 1'b0;
      count <= 5'h00;
    end else begin
      snapshot <= next_snapshot;
      busy <= next_busy;
      done <= next_done;
      count <= next_count;
    end
  end

endmodule

// ==== design/sdcp_sync_capture.sv ====
/*
  Sync delay and clock position capture top: register file on AXI4-Lite,
  delay step selection, sync hold latch, clear handling and the windowing
  circuit that snapshots input clock positions against a sync edge.
  Assumes syncPin and inputClock are asynchronous pins; the analog delay
  line takes the step size and total delay from the outputs here.
*/
`timescale 1ns/1ps

module sdcp_sync_capture
  import sdcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic syncPin,
  input wire logic inputClock,
  output logic [4:0] delayStepPs,
  output logic [10:0] syncDelayPs,
  output logic syncInternal,
  output logic windowEnable
);

  // ==========================================================
  // bus front end
  sdcp_reg_if regs ();

  sdcp_axil_slave u_slave (
    .clk(clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(regs)
  );

  // ==========================================================
  // register file

  // stored fields and bus strobes
  logic [1:0] delayStepSizeSel, next_delayStepSizeSel;
  logic [15:0] captureLatchControl, next_captureLatchControl;
  logic [15:0] syncControl, next_syncControl;
  logic stepLoWr, stepHiWr;
  logic [31:0] snapshot;
  logic winBusy, winDone;
  logic armed, clearSeen;

  // decoded control fields
  logic edgeCaptureEnable, syncHoldLatch, syncPathEnable, syncPathClear;
  logic [5:0] syncDelayTaps;

  assign edgeCaptureEnable = captureLatchControl[SDCP_CAPT_EN_BIT];
  assign syncHoldLatch = captureLatchControl[SDCP_CAPT_HOLD_BIT];
  assign syncPathClear = syncControl[SDCP_SCTL_CLEAR_BIT];
  assign syncPathEnable = syncControl[SDCP_SCTL_EN_BIT];
  assign syncDelayTaps = syncControl[SDCP_SCTL_TAPS_LSB +: 6];

  // byte lane strobes
  assign stepLoWr = regs.wrEn && regs.wrStrb[0];
  assign stepHiWr = regs.wrEn && regs.wrStrb[1];

  // address decode for writes
  always_comb begin
    regs.wrErr = 1'b0;
    case (regs.wrAddr)
      SDCP_ADDR_STEP, SDCP_ADDR_CAPT, SDCP_ADDR_SCTL: regs.wrErr = 1'b0;
      SDCP_ADDR_SNAPLO, SDCP_ADDR_SNAPHI, SDCP_ADDR_STAT: regs.wrErr = 1'b0;
      default: regs.wrErr = 1'b1;
    endcase
  end

  // next register values, byte lanes applied to the low 16 bits
  always_comb begin
    next_delayStepSizeSel = delayStepSizeSel;
    next_captureLatchControl = captureLatchControl;
    next_syncControl = syncControl;

    if (stepLoWr && regs.wrAddr == SDCP_ADDR_STEP) begin
      // only bits 1-0 are stored
      next_delayStepSizeSel = regs.wrData[1:0];
    end
    if (regs.wrAddr == SDCP_ADDR_CAPT) begin
      if (stepLoWr) begin
        next_captureLatchControl[7:0] = regs.wrData[7:0];
      end
      if (stepHiWr) begin
        next_captureLatchControl[15:8] = regs.wrData[15:8];
      end
    end

    if (regs.wrAddr == SDCP_ADDR_SCTL) begin
      if (stepLoWr) begin
        next_syncControl[7:0] = regs.wrData[7:0];
      end
      if (stepHiWr) begin
        next_syncControl[15:8] = regs.wrData[15:8];
      end
    end
  end

  // register storage
  always_ff @(posedge clk) begin
    if (rst) begin
      delayStepSizeSel <= SDCP_STEP_RESET[1:0]; // default 8 ps
      // capture control resets with bit 1 set
      captureLatchControl <= SDCP_CAPT_RESET;
      syncControl <= SDCP_SCTL_RESET;
    end else begin
      delayStepSizeSel <= next_delayStepSizeSel;
      captureLatchControl <= next_captureLatchControl;
      syncControl <= next_syncControl;
    end
  end

  // read mux, narrow data in the low bits
  always_comb begin
    regs.rdData = 32'h00000000;
    regs.rdErr = 1'b0;
    case (regs.rdAddr)
      SDCP_ADDR_STEP: regs.rdData = {30'h0, delayStepSizeSel};
      SDCP_ADDR_CAPT: regs.rdData = {16'h0000, captureLatchControl};
      SDCP_ADDR_SCTL: regs.rdData = {16'h0000, syncControl};
      SDCP_ADDR_SNAPLO: regs.rdData = {16'h0000, snapshot[15:0]};
      SDCP_ADDR_SNAPHI: regs.rdData = {16'h0000, snapshot[31:16]};
      // status: armed, done, busy, sync
      SDCP_ADDR_STAT: regs.rdData = {28'h0000000, armed, winDone,
        winBusy, syncInternal};
      default: regs.rdErr = 1'b1;
    endcase
  end

  // ==========================================================
  // pin synchronisers
  logic syncMeta, syncSafe, syncPrev, clkMeta, clkSafe;
  logic syncRise;

  // two flip-flops per pin plus a third on sync for the edge; only the second and that third are read
  always_ff @(posedge clk) begin
    if (rst) begin
      syncMeta <= 1'b0;
      syncSafe <= 1'b0;
      syncPrev <= 1'b0;
      clkMeta <= 1'b0;
      clkSafe <= 1'b0;
    end else begin
      syncMeta <= syncPin;
      syncSafe <= syncMeta;
      syncPrev <= syncSafe;
      clkMeta <= inputClock;
      clkSafe <= clkMeta;
    end
  end

  // rising edge of the safe pin
  assign syncRise = syncSafe && !syncPrev;

  // ==========================================================
  // delay line settings
  logic [4:0] next_delayStepPs;
  logic [10:0] next_syncDelayPs;

  // step lookup and total delay toward the analog line
  always_comb begin
    case (delayStepSizeSel)
      2'h0: next_delayStepPs = SDCP_STEP_PS_0;
      2'h1: next_delayStepPs = SDCP_STEP_PS_1;
      2'h2: next_delayStepPs = SDCP_STEP_PS_2;
      2'h3: next_delayStepPs = SDCP_STEP_PS_3;
      default: next_delayStepPs = SDCP_STEP_PS_3;
    endcase

    // sync delay is the step times the six-bit tap count
    next_syncDelayPs = 11'(next_delayStepPs) *
      11'(syncDelayTaps);
  end

  // ==========================================================
  // internal sync, hold latch and window arming
  logic syncLatched, next_syncLatched, next_syncInternal;
  logic next_armed, next_clearSeen, next_windowEnable, winStart;

  // capture starts only while armed
  assign winStart = armed && windowEnable && syncRise;

  // sync state and arming, clear dominates all but the window enable
  always_comb begin
    next_syncLatched = syncLatched;
    next_armed = armed;
    next_clearSeen = clearSeen;

    // window only with both enables, and
    next_windowEnable = syncPathEnable && edgeCaptureEnable;
    if (syncPathClear) begin
      next_syncLatched = 1'b0; // and
      next_clearSeen = 1'b1;
      next_armed = 1'b0;
    end else begin
      if (syncPathEnable && syncHoldLatch && syncRise) begin
        next_syncLatched = 1'b1;
      end

      if (clearSeen) begin
        next_clearSeen = 1'b0;
        next_armed = 1'b1;
      end else if (winStart) begin
        next_armed = 1'b0;
      end
    end

    // output level: clear, enable, hold
    if (syncPathClear || !syncPathEnable) begin
      next_syncInternal = 1'b0; // and
    end else if (syncHoldLatch) begin
      next_syncInternal = syncLatched || syncRise;
    end else begin
      next_syncInternal = syncSafe;
    end
  end

  // sync state registers and outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      syncLatched <= 1'b0;
      syncInternal <= 1'b0;
      armed <= 1'b0;
      clearSeen <= 1'b0;
      windowEnable <= 1'b0;
      delayStepPs <= SDCP_STEP_PS_3;
      syncDelayPs <= 11'h000;
    end else begin
      syncLatched <= next_syncLatched;
      syncInternal <= next_syncInternal;
      armed <= next_armed;
      clearSeen <= next_clearSeen;
      windowEnable <= next_windowEnable;
      delayStepPs <= next_delayStepPs;
      syncDelayPs <= next_syncDelayPs;
    end
  end

  // ==========================================================
  // windowing circuit, cleared by the clear bit
  sdcp_edge_window u_window (
    .clk(clk),
    .rst(rst),
    .clear(syncPathClear),
    .start(winStart),
    .sample(clkSafe),
    .snapshot(snapshot),
    .busy(winBusy),
    .done(winDone)
  );

endmodule

// ==== tb/sdcp_sync_capture_properties.sv ====
/*
  Concurrent checks for the sync capture top, bound to its ports.
  Assumes the bench offers write address and data together, both lanes.
*/
`timescale 1ns/1ps

module sdcp_sync_capture_properties
  import sdcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic syncPin,
  input wire logic [4:0] delayStepPs,
  input wire logic [10:0] syncDelayPs,
  input wire logic syncInternal,
  input wire logic windowEnable
);
  logic wrHit;
  logic [1:0] stepSh, next_stepSh;
  logic [15:0] captSh, next_captSh, sctlSh, next_sctlSh;
  logic [3:0] clrHist, enHist, capHist, holdHist;
  logic [3:0] next_clrHist, next_enHist, next_capHist, next_holdHist;

  // ==========================================================
  // shadow registers
  // shadow copies update on the write handshake, ahead of the design
  assign wrHit = awvalid && awready && wvalid && wready;
  always_comb begin
    next_stepSh = stepSh;
    next_captSh = captSh;
    next_sctlSh = sctlSh;
    if (wrHit && awaddr == SDCP_ADDR_STEP) next_stepSh = wdata[1:0];
    if (wrHit && awaddr == SDCP_ADDR_CAPT) next_captSh = wdata[15:0];
    if (wrHit && awaddr == SDCP_ADDR_SCTL) next_sctlSh = wdata[15:0];
    next_clrHist = {clrHist[2:0], sctlSh[0]};
    next_enHist = {enHist[2:0], sctlSh[13]};
    next_capHist = {capHist[2:0], captSh[2]};
    next_holdHist = {holdHist[2:0], captSh[0]};
  end

  // register the shadows and their short histories
  always_ff @(posedge clk) begin
    if (rst) begin
      stepSh <= 2'h3;
      captSh <= 16'h0002;
      sctlSh <= 16'h0001;
      clrHist <= 4'hF;
      enHist <= 4'h0;
      capHist <= 4'h0;
      holdHist <= 4'h0;
    end else begin
      stepSh <= next_stepSh;
      captSh <= next_captSh;
      sctlSh <= next_sctlSh;
      clrHist <= next_clrHist;
      enHist <= next_enHist;
      capHist <= next_capHist;
      holdHist <= next_holdHist;
    end
  end

  // step size in ps for a selector code
  function automatic logic [4:0] ps_of(input logic [1:0] c);
    case (c)
      2'h0: ps_of = SDCP_STEP_PS_0;
      2'h1: ps_of = SDCP_STEP_PS_1;
      2'h2: ps_of = SDCP_STEP_PS_2;
      default: ps_of = SDCP_STEP_PS_3;
    endcase
  endfunction

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_step_reset: assert property ($past(rst) |-> delayStepPs == 5'h08)
    else $error("step size not 8 ps after reset");
  a_step_follow: assert property (wrHit && awaddr == SDCP_ADDR_STEP
    |-> ##[1:4] delayStepPs == ps_of(stepSh))
    else $error("step size does not follow selector");
  a_delay_mult: assert property ($stable(delayStepPs) |->
    syncDelayPs % delayStepPs == 0 && syncDelayPs <= 11'd63 * delayStepPs)
    else $error("sync delay not a tap multiple of step");
  a_clear_low: assert property (&clrHist |-> !syncInternal)
    else $error("internal sync high while clear held");
  a_off_low: assert property (~|enHist |-> !syncInternal && !windowEnable)
    else $error("sync path off but sync or window active");
  a_window_on: assert property (&enHist && &capHist |-> windowEnable)
    else $error("window not enabled");
  a_window_cause: assert property ($rose(windowEnable) |->
    sctlSh[13] && captSh[2])
    else $error("window enabled without both enables");
  a_latch_hold: assert property (syncInternal && &holdHist &&
    captSh[0] && !sctlSh[0] && sctlSh[13] |=> syncInternal)
    else $error("latched sync dropped without clear");
  a_rise_cause: assert property ($rose(syncInternal) |->
    $past(syncPin, 3) || $past(syncPin, 4) || $past(syncPin, 5))
    else $error("internal sync rose without a pin pulse");
endmodule

bind sdcp_sync_capture sdcp_sync_capture_properties u_props (.clk, .rst,
  .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .syncPin,
  .delayStepPs, .syncDelayPs, .syncInternal, .windowEnable);

// ==== tb/sdcp_sync_source.sv ====
/*
  Far-side model: external sync pulse source and free-running input clock.
  Assumes fire is a one-cycle request on the system clock.
*/
`timescale 1ns/1ps

module sdcp_sync_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  output logic syncPin,
  output logic inputClock
);
  logic [2:0] phase, next_phase;
  logic [3:0] width, next_width;

  // ==========================================================
  // pulse and clock generation
  // clock runs free, three cycles high and three low; a request gives
  // an eight-cycle pulse, long enough for the pin synchroniser
  always_comb begin
    next_phase = (phase == 3'h5) ? 3'h0 : phase + 3'h1;
    next_width = (width != 4'h0) ? width - 4'h1 : 4'h0;
    if (fire && width == 4'h0) next_width = 4'h8;
  end

  // register the generator state
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= 3'h0;
      width <= 4'h0;
    end else begin
      phase <= next_phase;
      width <= next_width;
    end
  end

  assign syncPin = (width != 4'h0);
  assign inputClock = (phase < 3'h3);
endmodule

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the sync capture top over AXI4-Lite.
  Assumes the far-side model gives a period-six input clock.
*/
`timescale 1ns/1ps

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_top
  import sdcp_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, fire = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rd, snap, snap2;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, syncPin, inputClock;
  logic syncInternal, windowEnable, same;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] delayStepPs;
  logic [10:0] syncDelayPs;
  int num_errors = 0, tests_run = 0, seed = 27, taps, n;
  int regModel[int];
  int psTab[4] = '{28, 15, 11, 8};

  // ==========================================================
  // design and far side
  sdcp_sync_capture dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .syncPin, .inputClock,
    .delayStepPs, .syncDelayPs, .syncInternal, .windowEnable);
  sdcp_sync_source src (.clk, .rst, .fire, .syncPin, .inputClock);

  // free-running 250 MHz clock
  always #2 clk = ~clk;

  // ==========================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // bound on every wait
  task automatic tick(input int k);
    if (k > 100) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
  endtask

  // settle point away from the sampling edge
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // one write, response checked, bench model updated
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d,
    input logic [1:0] er);
    logic aw, w, b;
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      aw = awready;
      w = wready;
      b = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b) bready <= 1'h0;
      tick(k++);
    end while (!b);
    `CHK(rs, er)
    if (er == SDCP_RESP_OKAY) regModel[a] = (a == SDCP_ADDR_STEP) ? d & 3 : d;
  endtask

  // one read; data and response returned
  task automatic bus_rd(input logic [7:0] a);
    logic ar, got;
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      ar = arready;
      got = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'h0;
      if (got) rready <= 1'h0;
      tick(k++);
    end while (!got);
  endtask

  // read compared with the bench model
  task automatic chk_reg(input logic [7:0] a);
    bus_rd(a);
    `CHK(rd, 32'(regModel.exists(a) ? regModel[a] : 0))
    `CHK(rs, regModel.exists(a) ? SDCP_RESP_OKAY : SDCP_RESP_SLVERR)
  endtask

  // whole snapshot from its two halves
  task automatic get_snap();
    bus_rd(SDCP_ADDR_SNAPLO);
    snap[15:0] = rd[15:0];
    bus_rd(SDCP_ADDR_SNAPHI);
    snap[31:16] = rd[15:0];
  endtask

  // one sync pulse request
  task automatic pulse();
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    regModel[SDCP_ADDR_STEP] = 3;
    regModel[SDCP_ADDR_CAPT] = 2;
    regModel[SDCP_ADDR_SCTL] = 1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    // reset values, then an unmapped write and read
    chk_reg(SDCP_ADDR_STEP);
    chk_reg(SDCP_ADDR_CAPT);
    chk_reg(SDCP_ADDR_SCTL);
    bus_wr(8'h3C, 16'hFFFF, SDCP_RESP_SLVERR);
    chk_reg(8'h3C);
    endt("reset");
    // every step code with ones in the reserved bits and random taps
    for (int c = 0; c < 4; c++) begin
      taps = $random(seed) & 63;
      bus_wr(SDCP_ADDR_STEP, 16'(16'hFFFC | c), SDCP_RESP_OKAY);
      bus_wr(SDCP_ADDR_SCTL, 16'(taps << 1), SDCP_RESP_OKAY);
      cyc(3);
      chk_reg(SDCP_ADDR_STEP);
      `CHK(delayStepPs, 5'(psTab[c]))
      `CHK(syncDelayPs, 11'(taps * psTab[c]))
    end
    endt("step");
    // window enable against both enables
    for (int m = 0; m < 4; m++) begin
      bus_wr(SDCP_ADDR_SCTL, 16'((m & 2) << 12), SDCP_RESP_OKAY);
      bus_wr(SDCP_ADDR_CAPT, 16'((m & 1) * 4 + 2), SDCP_RESP_OKAY);
      cyc(3);
      `CHK(windowEnable, 1'(m == 3))
    end
    endt("gate");
    // capture: clear toggled, one pulse, snapshot shape checked, a second pulse leaves it, clear empties it
    bus_wr(SDCP_ADDR_SCTL, 16'h2001, SDCP_RESP_OKAY);
    bus_wr(SDCP_ADDR_SCTL, 16'h2000, SDCP_RESP_OKAY);
    pulse();
    n = 0;
    do begin
      bus_rd(SDCP_ADDR_STAT);
      tick(n++);
    end while (rd[2] !== 1'h1);
    get_snap();
    `CHK({snap[31], snap[0]}, 2'h3)
    `CHK(5'($countones(snap[30:1])), 5'h0F)
    same = 1'h1;
    for (int i = 1; i < 25; i++) same &= (snap[i] === snap[i + 6]);
    `CHK(same, 1'h1)
    snap2 = snap;
    pulse();
    cyc(50);
    get_snap();
    `CHK(snap, snap2)
    bus_wr(SDCP_ADDR_SCTL, 16'h2001, SDCP_RESP_OKAY);
    get_snap();
    `CHK(snap, 32'h0)
    endt("capture");
    // path disabled: no capture even with capture enable set
    bus_wr(SDCP_ADDR_SCTL, 16'h0000, SDCP_RESP_OKAY);
    pulse();
    cyc(50);
    bus_rd(SDCP_ADDR_STAT);
    `CHK(rd[2], 1'h0)
    endt("disabled");
    // hold latch: set by a pulse, released by clear, low while clear
    bus_wr(SDCP_ADDR_CAPT, 16'h0003, SDCP_RESP_OKAY);
    bus_wr(SDCP_ADDR_SCTL, 16'h2001, SDCP_RESP_OKAY);
    bus_wr(SDCP_ADDR_SCTL, 16'h2000, SDCP_RESP_OKAY);
    pulse();
    cyc(20);
    `CHK(syncInternal, 1'h1)
    bus_wr(SDCP_ADDR_SCTL, 16'h2001, SDCP_RESP_OKAY);
    cyc(3);
    `CHK(syncInternal, 1'h0)
    pulse();
    cyc(6);
    `CHK(syncInternal, 1'h0)
    bus_wr(SDCP_ADDR_CAPT, 16'h0002, SDCP_RESP_OKAY);
    bus_wr(SDCP_ADDR_SCTL, 16'h2000, SDCP_RESP_OKAY);
    pulse();
    cyc(6);
    `CHK(syncInternal, 1'h1)
    cyc(20);
    `CHK(syncInternal, 1'h0)
    endt("latch");
    complete_run();
  end
endmodule
